// file: hdl/sfp_defs.vh
// Constants for the serial flash read and program sequencer.
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Opcodes.
`define SFP_OP_READ 8'h03
`define SFP_OP_FAST_READ 8'h0B
`define SFP_OP_BYTE_PROG 8'h02
`define SFP_OP_AUTO_INC_PROG 8'hAD
`define SFP_OP_SECTOR_ERASE 8'h20
`define SFP_OP_BLOCK32_ERASE 8'h52
`define SFP_OP_BLOCK64_ERASE 8'hD8
`define SFP_OP_READ_STATUS 8'h05
`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_WRITE_DISABLE 8'h04
`define SFP_OP_READ_ID_A 8'h90
`define SFP_OP_READ_ID_B 8'hAB
`define SFP_OP_BUSY_OUT_ENABLE 8'h70
`define SFP_OP_BUSY_OUT_DISABLE 8'h80

// Status byte layout.
`define SFP_ST_BUSY 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LO 2
`define SFP_ST_AAI 6
`define SFP_ST_BPL 7

// Memory map of the 4 Mbit array.
`define SFP_ADDR_W 19
`define SFP_TOP_WORD 18'h3FFFF
`define SFP_MASK_SECTOR 19'h7F000
`define SFP_MASK_BLOCK32 19'h78000
`define SFP_MASK_BLOCK64 19'h70000
`define SFP_PROT_EIGHTH 19'h70000
`define SFP_PROT_QUARTER 19'h60000
`define SFP_PROT_HALF 19'h40000

// Erase kinds reported on the erase request.
`define SFP_ERASE_SECTOR 2'h0
`define SFP_ERASE_BLOCK32 2'h1
`define SFP_ERASE_BLOCK64 2'h2

// Timing.
`define SFP_CLK_PERIOD_NS 25
`define SFP_BYTE_PROGRAM_TIME_NS 10000
`define SFP_PROG_CYCLES (`SFP_BYTE_PROGRAM_TIME_NS / `SFP_CLK_PERIOD_NS)

`endif

// file: hdl/sfp_sync.v
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module sfp_sync #(
  parameter WIDTH = 3
) (
  input wire clk_sys,
  input wire resetn,
  input wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= d_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign q_out[i] = sync_reg;
    end
  endgenerate
endmodule

// file: hdl/sfp_prog_timer.v
// Self-timed program cycle timer that holds the busy flag.
`timescale 1ns/1ps
module sfp_prog_timer #(
  parameter CYCLES = 400,
  parameter CNT_W = 16
) (
  input wire clk_sys,
  input wire resetn,
  input wire start,
  output reg busy_reg
);
  reg [CNT_W-1:0] cnt_reg;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
      busy_reg <= 1'b1;
    end else if (cnt_reg != {CNT_W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      busy_reg <= 1'b0;
    end
  end
endmodule

// file: hdl/sfp_flash.v
// Serial flash command sequencer: reads, byte and auto-increment programming.
// How it works
// - Every opcode, address and data byte takes exactly eight serial clocks.
// - Sector erase keeps address bits top down to 12, clears the rest.
// - 32K block erase keeps address bits top down to 15.
// - 64K block erase keeps address bits top down to 16.
// - Read status resends the live status byte until chip select rises.
// - Identification read alternates maker and part code from address bit 0.
// - Normal read 03H takes three address bytes, streams with address increment.
// - The read pointer wraps from the top location to zero.
// - Fast read 0BH adds one dummy byte before streaming.
// - Byte program 02H, address, one byte; runs when chip select rises.
// - Byte program into a protected region is dropped.
// - Program and erase need the write enable latch set.
// - Busy shows in status while the self-timed program runs.
// - Auto-increment start address in a protected region is ignored.
// - In auto-increment mode only ADH, 04H and (no busy pin) 05H work.
// - First ADH has address and two bytes; later ADH only two bytes.
// - Write disable clears latch and auto-increment; 80H ends busy pin mode.
// - Auto-increment never wraps; it stops after the top unprotected word.
// - 70H turns the serial output into a ready/busy pin while auto-increment mode is active.
// - In that mode chip select low drives ready/busy, high releases output.
// - Commands start at chip select fall; bits sampled on rising clock.
// - Chip select rising mid-byte aborts the command.
// - Write enable sets the write enable latch.
`timescale 1ns/1ps
`include "sfp_defs.vh"
module sfp_flash #(
  parameter [7:0] MAKER_CODE = 8'h5A,
  parameter [7:0] PART_CODE = 8'hC3,
  parameter PROG_CYCLES = `SFP_PROG_CYCLES
) (
  input wire clk_sys,
  input wire resetn,
  input wire ce_n,
  input wire sck,
  input wire si,
  output reg so_reg,
  output reg so_oe_n_reg,
  input wire [3:0] block_prot,
  input wire prot_lock,
  output reg [18:0] mem_addr_reg,
  input wire [7:0] mem_rdata,
  output reg [7:0] mem_wdata_reg,
  output reg mem_wr_reg,
  output reg erase_req_reg,
  output reg [18:0] erase_addr_reg,
  output reg [1:0] erase_kind_reg,
  output wire status_busy,
  output reg status_wel_reg,
  output reg status_aai_reg,
  output reg status_busy_out_en_reg
);
  // The ID codes are arbitrary neutral values.

  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_DATA = 3'd4;
  localparam ST_OUT = 3'd5;
  localparam ST_SKIP = 3'd6;

  ////////////////////////////////////////////////////////////////////////////
  wire [2:0] pin_s;
  reg ce_d_reg;
  reg sck_d_reg;
  sfp_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d_in({ce_n, sck, si}),
    .q_out(pin_s)
  );
  wire ce_s = pin_s[2];
  wire sck_s = pin_s[1];
  wire si_s = pin_s[0];
  wire sck_rise = sck_s & ~sck_d_reg & ~ce_s;
  wire sck_fall = ~sck_s & sck_d_reg & ~ce_s;
  wire ce_fall = ~ce_s & ce_d_reg;
  wire ce_rise = ce_s & ~ce_d_reg;

  reg prog_start_reg;
  sfp_prog_timer #(.CYCLES(PROG_CYCLES), .CNT_W(16)) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .start(prog_start_reg),
    .busy_reg(status_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] state_reg;
  reg [2:0] bit_reg;
  reg [6:0] rx_reg;
  reg [7:0] op_reg;
  reg [1:0] cnt_reg;
  reg [23:0] addr_reg;
  reg [7:0] d0_reg;
  reg [7:0] d1_reg;
  reg done_reg;
  reg [6:0] tx_reg;
  reg [2:0] obit_reg;
  reg [18:0] rd_ptr_reg;
  reg id_sel_reg;
  reg [18:0] aai_addr_reg;
  reg wr2_pend_reg;

  wire [7:0] rx_byte = {rx_reg, si_s};
  wire byte_done = sck_rise & (bit_reg == 3'd7);
  wire [7:0] status_byte = {prot_lock, status_aai_reg, block_prot, status_wel_reg, status_busy};
  wire [18:0] aai_next = aai_addr_reg + 19'h00002;
  wire is_id = (op_reg == `SFP_OP_READ_ID_A) | (op_reg == `SFP_OP_READ_ID_B);
  wire [7:0] src_byte = (op_reg == `SFP_OP_READ_STATUS) ? status_byte :
                        is_id ? (id_sel_reg ? PART_CODE : MAKER_CODE) : mem_rdata;

  function prot_hit;
    input [18:0] a;
    input [2:0] bp;
    begin
      case (bp)
        3'd0: prot_hit = 1'b0;
        3'd1: prot_hit = (a >= `SFP_PROT_EIGHTH);
        3'd2: prot_hit = (a >= `SFP_PROT_QUARTER);
        3'd3: prot_hit = (a >= `SFP_PROT_HALF);
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // Opcode filter; outside auto-increment mode, only status reads get through while a program is running.
  reg op_ok;
  always @* begin
    if (status_aai_reg) begin
      op_ok = (rx_byte == `SFP_OP_AUTO_INC_PROG) | (rx_byte == `SFP_OP_WRITE_DISABLE) |
              ((rx_byte == `SFP_OP_READ_STATUS) & ~status_busy_out_en_reg);
    end else if (status_busy) begin
      op_ok = (rx_byte == `SFP_OP_READ_STATUS);
    end else begin
      op_ok = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ce_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bit_reg <= 3'd0;
      rx_reg <= 7'h00;
      op_reg <= 8'h00;
      cnt_reg <= 2'd0;
      addr_reg <= 24'h000000;
      d0_reg <= 8'hFF;
      d1_reg <= 8'hFF;
      done_reg <= 1'b0;
      tx_reg <= 7'h00;
      obit_reg <= 3'd0;
      rd_ptr_reg <= 19'h00000;
      id_sel_reg <= 1'b0;
    end else begin
      ce_d_reg <= ce_s;
      sck_d_reg <= sck_s;
      if (ce_fall) begin
        state_reg <= ST_CMD;
        bit_reg <= 3'd0;
        cnt_reg <= 2'd0;
        done_reg <= 1'b0;
        obit_reg <= 3'd0;
      end else if (ce_rise) begin
        state_reg <= ST_IDLE;
      end else if (sck_rise) begin
        rx_reg <= rx_byte[6:0];
        bit_reg <= bit_reg + 3'd1;
        if (byte_done) begin
          cnt_reg <= cnt_reg + 2'd1;
          case (state_reg)
            ST_CMD: begin
              op_reg <= rx_byte;
              cnt_reg <= 2'd0;
              if (!op_ok) begin
                state_reg <= ST_SKIP;
              end else if (rx_byte == `SFP_OP_READ_STATUS) begin
                state_reg <= ST_OUT;
              end else if (rx_byte == `SFP_OP_AUTO_INC_PROG && status_aai_reg) begin
                state_reg <= ST_DATA;
              end else if (rx_byte == `SFP_OP_READ || rx_byte == `SFP_OP_FAST_READ ||
                           rx_byte == `SFP_OP_READ_ID_A || rx_byte == `SFP_OP_READ_ID_B ||
                           rx_byte == `SFP_OP_BYTE_PROG || rx_byte == `SFP_OP_AUTO_INC_PROG ||
                           rx_byte == `SFP_OP_SECTOR_ERASE || rx_byte == `SFP_OP_BLOCK32_ERASE ||
                           rx_byte == `SFP_OP_BLOCK64_ERASE) begin
                state_reg <= ST_ADDR;
              end else begin
                state_reg <= ST_SKIP;
                done_reg <= 1'b1;
              end
            end
            ST_ADDR: begin
              addr_reg <= {addr_reg[15:0], rx_byte};
              if (cnt_reg == 2'd2) begin
                cnt_reg <= 2'd0;
                rd_ptr_reg <= {addr_reg[10:0], rx_byte};
                id_sel_reg <= rx_byte[0];
                if (op_reg == `SFP_OP_READ || is_id) begin
                  state_reg <= ST_OUT;
                end else if (op_reg == `SFP_OP_FAST_READ) begin
                  state_reg <= ST_DUMMY;
                end else if (op_reg == `SFP_OP_BYTE_PROG || op_reg == `SFP_OP_AUTO_INC_PROG) begin
                  state_reg <= ST_DATA;
                end else begin
                  state_reg <= ST_SKIP;
                  done_reg <= 1'b1;
                end
              end
            end
            ST_DUMMY: begin
              state_reg <= ST_OUT;
            end
            ST_DATA: begin
              if (cnt_reg == 2'd0) begin
                d0_reg <= rx_byte;
              end else begin
                d1_reg <= rx_byte;
              end
              if (op_reg == `SFP_OP_BYTE_PROG || cnt_reg == 2'd1) begin
                state_reg <= ST_SKIP;
                done_reg <= 1'b1;
              end
            end
            default: begin
              state_reg <= state_reg;
            end
          endcase
        end
      end else if (sck_fall && state_reg == ST_OUT) begin
        if (obit_reg == 3'd0) begin
          tx_reg <= src_byte[6:0];
          rd_ptr_reg <= rd_ptr_reg + 19'h00001;
          id_sel_reg <= ~id_sel_reg;
        end else begin
          tx_reg <= {tx_reg[5:0], 1'b0};
        end
        obit_reg <= obit_reg + 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output: while chip select is low, a ready/busy level owns the pin whenever that mode is on and auto-increment mode is active.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      so_reg <= 1'b1;
      so_oe_n_reg <= 1'b1;
    end else if (ce_s) begin
      so_oe_n_reg <= 1'b1;
    end else if (status_busy_out_en_reg && status_aai_reg) begin
      so_oe_n_reg <= 1'b0;
      so_reg <= ~status_busy;
    end else if (sck_fall && state_reg == ST_OUT) begin
      so_oe_n_reg <= 1'b0;
      so_reg <= (obit_reg == 3'd0) ? src_byte[7] : tx_reg[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame end: a command runs only if its last byte arrived whole.
  wire exec = ce_rise & done_reg & (bit_reg == 3'd0);
  wire [18:0] cmd_addr = addr_reg[18:0];
  wire cmd_prot = prot_hit(cmd_addr, block_prot[2:0]);
  wire aai_stop = (aai_addr_reg[18:1] == `SFP_TOP_WORD) | prot_hit(aai_next, block_prot[2:0]);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_wel_reg <= 1'b0;
      status_aai_reg <= 1'b0;
      status_busy_out_en_reg <= 1'b0;
      aai_addr_reg <= 19'h00000;
      mem_addr_reg <= 19'h00000;
      mem_wdata_reg <= 8'hFF;
      mem_wr_reg <= 1'b0;
      wr2_pend_reg <= 1'b0;
      prog_start_reg <= 1'b0;
      erase_req_reg <= 1'b0;
      erase_addr_reg <= 19'h00000;
      erase_kind_reg <= `SFP_ERASE_SECTOR;
    end else begin
      mem_wr_reg <= 1'b0;
      prog_start_reg <= 1'b0;
      erase_req_reg <= 1'b0;
      wr2_pend_reg <= 1'b0;
      if (wr2_pend_reg) begin
        mem_addr_reg <= {mem_addr_reg[18:1], 1'b1};
        mem_wdata_reg <= d1_reg;
        mem_wr_reg <= 1'b1;
      end else if (state_reg == ST_ADDR && byte_done && cnt_reg == 2'd2) begin
        mem_addr_reg <= {addr_reg[10:0], rx_byte};
      end else if (sck_fall && state_reg == ST_OUT && obit_reg == 3'd0) begin
        mem_addr_reg <= rd_ptr_reg + 19'h00001;
      end
      if (exec) begin
        case (op_reg)
          `SFP_OP_WRITE_ENABLE: begin
            status_wel_reg <= 1'b1;
          end
          `SFP_OP_WRITE_DISABLE: begin
            status_wel_reg <= 1'b0;
            status_aai_reg <= 1'b0;
          end
          `SFP_OP_BUSY_OUT_ENABLE: begin
            status_busy_out_en_reg <= 1'b1;
          end
          `SFP_OP_BUSY_OUT_DISABLE: begin
            status_busy_out_en_reg <= 1'b0;
          end
          `SFP_OP_BYTE_PROG: begin
            if (status_wel_reg && !cmd_prot) begin
              mem_addr_reg <= cmd_addr;
              mem_wdata_reg <= d0_reg;
              mem_wr_reg <= 1'b1;
              prog_start_reg <= 1'b1;
              status_wel_reg <= 1'b0;
            end
          end
          `SFP_OP_AUTO_INC_PROG: begin
            if (!status_aai_reg) begin
              if (status_wel_reg && !cmd_prot) begin
                status_aai_reg <= 1'b1;
                aai_addr_reg <= {cmd_addr[18:1], 1'b0};
                mem_addr_reg <= {cmd_addr[18:1], 1'b0};
                mem_wdata_reg <= d0_reg;
                mem_wr_reg <= 1'b1;
                wr2_pend_reg <= 1'b1;
                prog_start_reg <= 1'b1;
              end
            end else if (!aai_stop) begin
              aai_addr_reg <= aai_next;
              mem_addr_reg <= aai_next;
              mem_wdata_reg <= d0_reg;
              mem_wr_reg <= 1'b1;
              wr2_pend_reg <= 1'b1;
              prog_start_reg <= 1'b1;
            end
          end
          `SFP_OP_SECTOR_ERASE, `SFP_OP_BLOCK32_ERASE, `SFP_OP_BLOCK64_ERASE: begin
            if (status_wel_reg && !cmd_prot) begin
              erase_req_reg <= 1'b1;
              status_wel_reg <= 1'b0;
              if (op_reg == `SFP_OP_SECTOR_ERASE) begin
                erase_addr_reg <= cmd_addr & `SFP_MASK_SECTOR;
                erase_kind_reg <= `SFP_ERASE_SECTOR;
              end else if (op_reg == `SFP_OP_BLOCK32_ERASE) begin
                erase_addr_reg <= cmd_addr & `SFP_MASK_BLOCK32;
                erase_kind_reg <= `SFP_ERASE_BLOCK32;
              end else begin
                erase_addr_reg <= cmd_addr & `SFP_MASK_BLOCK64;
                erase_kind_reg <= `SFP_ERASE_BLOCK64;
              end
            end
          end
          default: begin
            status_wel_reg <= status_wel_reg;
          end
        endcase
      end
    end
  end
endmodule

// file: sim/sfp_flash_assertions.sv
// Port-level checks for the serial flash sequencer.
`timescale 1ns/1ps
module sfp_flash_assertions (
  input wire clk_sys,
  input wire resetn,
  input wire ce_n,
  input wire sck,
  input wire so_reg,
  input wire so_oe_n_reg,
  input wire [3:0] block_prot,
  input wire [18:0] mem_addr_reg,
  input wire mem_wr_reg,
  input wire erase_req_reg,
  input wire [18:0] erase_addr_reg,
  input wire [1:0] erase_kind_reg,
  input wire status_busy,
  input wire status_wel_reg,
  input wire status_busy_out_en_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Protection decode written apart from the design, so one shared slip cannot hide itself.
  wire prot_hit = block_prot[2] || (block_prot[1:0] == 2'h1 && mem_addr_reg >= 19'h70000) ||
    (block_prot[1:0] == 2'h2 && mem_addr_reg >= 19'h60000) || (block_prot[1:0] == 2'h3 && mem_addr_reg[18]);
  sequence s_prog_start;
    $rose(mem_wr_reg);
  endsequence
  sequence s_ce_idle;
    ce_n [*6];
  endsequence
  AST_WR_BUSY: assert property (s_prog_start |=> status_busy [*8])
    else $error("busy missing after program");
  AST_BUSY_SRC: assert property ($rose(status_busy) |-> $past(mem_wr_reg))
    else $error("busy without program");
  AST_WR_WEL: assert property (s_prog_start |-> status_wel_reg || $past(status_wel_reg) || $past(status_wel_reg, 2))
    else $error("program without write enable");
  AST_WR_PROT: assert property (mem_wr_reg |-> !prot_hit)
    else $error("program into protected area");
  AST_ERASE_SEC: assert property (erase_req_reg && erase_kind_reg == 2'h0 |-> erase_addr_reg[11:0] == 12'h000)
    else $error("sector address not masked");
  AST_ERASE_B32: assert property (erase_req_reg && erase_kind_reg == 2'h1 |-> erase_addr_reg[14:0] == 15'h0000)
    else $error("32K block address not masked");
  AST_ERASE_B64: assert property (erase_req_reg && erase_kind_reg == 2'h2 |-> erase_addr_reg[15:0] == 16'h0000)
    else $error("64K block address not masked");
  AST_ERASE_PULSE: assert property (erase_req_reg |=> !erase_req_reg)
    else $error("erase request longer than one cycle");
  AST_OE_IDLE: assert property (s_ce_idle |-> so_oe_n_reg)
    else $error("output driven while deselected");
  AST_SO_EDGE: assert property ($changed(so_reg) && !so_oe_n_reg && !ce_n && !status_busy_out_en_reg |-> !$past(sck, 2))
    else $error("output changed away from falling clock");
endmodule
bind sfp_flash sfp_flash_assertions chk (.clk_sys(clk_sys), .resetn(resetn), .ce_n(ce_n), .sck(sck),
  .so_reg(so_reg), .so_oe_n_reg(so_oe_n_reg), .block_prot(block_prot), .mem_addr_reg(mem_addr_reg),
  .mem_wr_reg(mem_wr_reg), .erase_req_reg(erase_req_reg), .erase_addr_reg(erase_addr_reg),
  .erase_kind_reg(erase_kind_reg), .status_busy(status_busy), .status_wel_reg(status_wel_reg),
  .status_busy_out_en_reg(status_busy_out_en_reg));

// file: sim/sfp_host.sv
// Host serial controller model driving chip select, serial clock and data.
`timescale 1ns/1ps
module sfp_host (
  input wire clk_sys,
  output reg ce_n,
  output reg sck,
  output reg si,
  input wire so
);
  initial begin
    ce_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Eight clock periods a byte, bits sampled by the device on the rising clock.
  task bits(input [7:0] d, input integer n, output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        sck <= 1'b0;
        si <= d[i];
        wt(4);
        sck <= 1'b1;
        wt(4);
        q = {q[6:0], so};
      end
    end
  endtask
  // Opcode, address top byte first, data, then read bytes.
  task frame(input [7:0] op, input integer ob, input integer na, input [18:0] a, input integer nd,
    input [15:0] wd, input integer nr, output [31:0] rd);
    reg [23:0] ad;
    reg [7:0] q;
    integer k;
    begin
      ad = {5'h00, a};
      rd = 32'h0;
      ce_n <= 1'b0;
      wt(4);
      bits(op, ob > 8 ? 8 : ob, q);
      // Bits past eight trail the opcode as a cut byte, so an abort after a whole command is reachable.
      if (ob > 8)
        bits(8'hFF, ob - 8, q);
      for (k = 0; k < na; k = k + 1) begin
        bits(ad[23:16], 8, q);
        ad = ad << 8;
      end
      for (k = 0; k < nd; k = k + 1) begin
        bits(wd[15:8], 8, q);
        wd = wd << 8;
      end
      for (k = 0; k < nr; k = k + 1) begin
        bits(8'h00, 8, q);
        rd = {rd[23:0], q};
      end
      sck <= 1'b0;
      wt(4);
      ce_n <= 1'b1;
      si <= ~si;
      wt(10);
    end
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the serial flash sequencer.
`timescale 1ns/1ps
module tb;
  localparam [7:0] MK = 8'h3C;
  localparam [7:0] PT = 8'hA5;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] block_prot = 4'h0;
  reg prot_lock = 1'b0;
  wire ce_n, sck, si, so_reg, so_oe_n_reg, mem_wr_reg, erase_req_reg, status_busy;
  wire status_wel_reg, status_aai_reg, status_busy_out_en_reg;
  wire [18:0] mem_addr_reg, erase_addr_reg;
  wire [7:0] mem_wdata_reg, mem_rdata;
  wire [1:0] erase_kind_reg;
  wire so_pin = so_oe_n_reg ? 1'bz : so_reg;
  reg [7:0] mem [0:524287];
  reg [18:0] ea, a;
  reg [1:0] ek;
  reg [31:0] rd;
  reg [7:0] d0, d1;
  integer errors = 0, comparisons = 0, en = 0, i;
  always #12.5 clk_sys = ~clk_sys;
  sfp_host h (.clk_sys(clk_sys), .ce_n(ce_n), .sck(sck), .si(si), .so(so_pin));
  sfp_flash #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .ce_n(ce_n), .sck(sck), .si(si), .so_reg(so_reg), .so_oe_n_reg(so_oe_n_reg), .block_prot(block_prot),
    .prot_lock(prot_lock), .mem_addr_reg(mem_addr_reg), .mem_rdata(mem_rdata), .mem_wdata_reg(mem_wdata_reg),
    .mem_wr_reg(mem_wr_reg), .erase_req_reg(erase_req_reg), .erase_addr_reg(erase_addr_reg),
    .erase_kind_reg(erase_kind_reg), .status_busy(status_busy), .status_wel_reg(status_wel_reg),
    .status_aai_reg(status_aai_reg), .status_busy_out_en_reg(status_busy_out_en_reg));
  // Array model ANDs new data in, as real cells cannot return to one.
  assign mem_rdata = mem[mem_addr_reg];
  always @(posedge clk_sys) begin
    if (mem_wr_reg) mem[mem_addr_reg] <= mem[mem_addr_reg] & mem_wdata_reg;
    if (erase_req_reg) begin
      ea <= erase_addr_reg;
      ek <= erase_kind_reg;
      en <= en + 1;
    end
  end
  function [7:0] st(input auto_increment_program, input write_enable_latch, input busy);
    st = {prot_lock, auto_increment_program, block_prot, write_enable_latch, busy};
  endfunction
  function [18:0] emask(input [1:0] k);
    emask = k == 2'h0 ? 19'h7F000 : k == 2'h1 ? 19'h78000 : 19'h70000;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cmd(input [7:0] op);
    h.frame(op, 8, 0, 19'h0, 0, 16'h0, 0, rd);
  endtask
  task wait_ready;
    integer n;
    begin
      n = 0;
      while (status_busy !== 1'b0 && n < 1000) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      chk(status_busy, 0);
    end
  endtask
  task pin_check(input v);
    begin
      h.ce_n <= 1'b0;
      h.wt(8);
      chk({so_oe_n_reg, so_reg}, {1'b0, v});
      h.ce_n <= 1'b1;
      h.wt(8);
      chk(so_oe_n_reg, 1);
    end
  endtask
  task conclude;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #1500000;
    errors = errors + 1;
    conclude;
  end
  initial begin
    i = $urandom(32'h86939373);
    for (i = 0; i < 524288; i = i + 1) mem[i] = $urandom;
    prot_lock = $urandom;
    block_prot[3] = $urandom;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    h.wt(4);
    chk(so_oe_n_reg, 1);
    h.frame(8'h05, 8, 0, 19'h0, 0, 16'h0, 2, rd);
    chk(rd[15:0], {2{st(0, 0, 0)}});
    h.frame(8'h06, 7, 0, 19'h0, 0, 16'h0, 0, rd);
    chk(status_wel_reg, 0);
    h.frame(8'h06, 11, 0, 19'h0, 0, 16'h0, 0, rd);
    chk(status_wel_reg, 0);
    cmd(8'h06);
    chk(status_wel_reg, 1);
    a = $urandom;
    d0 = $urandom;
    mem[a] = 8'hFF;
    h.frame(8'h02, 8, 3, a, 1, {d0, 8'h00}, 0, rd);
    chk(status_busy, 1);
    h.frame(8'h05, 8, 0, 19'h0, 0, 16'h0, 1, rd);
    chk(rd[7:0], st(0, 0, 1));
    wait_ready;
    chk(mem[a], d0);
    mem[a] = 8'hFF;
    h.frame(8'h02, 8, 3, a, 1, {d0, 8'h00}, 0, rd);
    h.wt(20);
    chk(mem[a], 8'hFF);
    for (i = 1; i < 5; i = i + 1) begin
      block_prot[2:0] = i;
      cmd(8'h06);
      a = $urandom;
      a[18:16] = 3'h7;
      mem[a] = 8'hFF;
      h.frame(8'h02, 8, 3, a, 1, 16'h0000, 0, rd);
      h.wt(20);
      chk(mem[a], 8'hFF);
      cmd(8'h04);
    end
    block_prot[2:0] = 3'h0;
    h.frame(8'h03, 8, 3, 19'h7FFFE, 0, 16'h0, 4, rd);
    chk(rd, {mem[19'h7FFFE], mem[19'h7FFFF], mem[0], mem[1]});
    a = $urandom;
    h.frame(8'h0B, 8, 3, a, 1, 16'h0, 3, rd);
    chk(rd[23:0], {mem[a], mem[a + 19'h1], mem[a + 19'h2]});
    for (i = 0; i < 2; i = i + 1) begin
      h.frame(i ? 8'hAB : 8'h90, 8, 3, i, 0, 16'h0, 2, rd);
      chk(rd[15:0], i ? {PT, MK} : {MK, PT});
    end
    for (i = 0; i < 3; i = i + 1) begin
      cmd(8'h06);
      a = $urandom;
      h.frame(i == 0 ? 8'h20 : i == 1 ? 8'h52 : 8'hD8, 8, 3, a, 0, 16'h0, 0, rd);
      chk({en[3:0], ek, ea}, {i[3:0] + 4'h1, i[1:0], a & emask(i)});
    end
    block_prot[2:0] = 3'h1;
    cmd(8'h06);
    a = $urandom;
    a[18:16] = 3'h7;
    a[0] = 1'b0;
    mem[a] = 8'hFF;
    h.frame(8'hAD, 8, 3, a, 2, 16'h0000, 0, rd);
    h.wt(20);
    chk({status_aai_reg, mem[a]}, {1'b0, 8'hFF});
    cmd(8'h04);
    block_prot[2:0] = 3'h0;
    a = $urandom;
    a[18] = 1'b0;
    a[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) mem[a + i] = 8'hFF;
    d0 = $urandom;
    d1 = $urandom;
    cmd(8'h70);
    chk(status_busy_out_en_reg, 1);
    cmd(8'h06);
    h.frame(8'hAD, 8, 3, a, 2, {d0, d1}, 0, rd);
    pin_check(0);
    wait_ready;
    pin_check(1);
    h.frame(8'h05, 8, 0, 19'h0, 0, 16'h0, 1, rd);
    chk(rd[7:0], 8'hFF);
    h.frame(8'h02, 8, 3, a + 19'h8, 1, 16'h0000, 0, rd);
    h.wt(20);
    chk(mem[a + 8], 8'hFF);
    h.frame(8'hAD, 8, 0, 19'h0, 2, {d1, d0}, 0, rd);
    wait_ready;
    cmd(8'h04);
    chk({status_aai_reg, status_wel_reg}, 0);
    cmd(8'h80);
    chk(status_busy_out_en_reg, 0);
    chk({mem[a], mem[a + 1], mem[a + 2], mem[a + 3]}, {d0, d1, d1, d0});
    prot_lock = ~prot_lock;
    block_prot[3] = ~block_prot[3];
    mem[19'h7FFFE] = 8'hFF;
    mem[19'h7FFFF] = 8'hFF;
    mem[0] = 8'hFF;
    mem[1] = 8'hFF;
    cmd(8'h06);
    h.frame(8'hAD, 8, 3, 19'h7FFFF, 2, {d0, d1}, 0, rd);
    h.frame(8'h05, 8, 0, 19'h0, 0, 16'h0, 1, rd);
    chk(rd[7:0], st(1, 1, 1));
    wait_ready;
    h.frame(8'hAD, 8, 0, 19'h0, 2, 16'h0000, 0, rd);
    h.wt(20);
    chk({status_busy, mem[0], mem[1]}, {1'b0, 16'hFFFF});
    chk({mem[19'h7FFFE], mem[19'h7FFFF]}, {d0, d1});
    cmd(8'h04);
    chk({status_aai_reg, status_wel_reg}, 0);
    conclude;
  end
endmodule
